// *** bench/osc_freq_wdog_sva.sv ***
// Purpose: port checker for osc_freq_wdog
// Assumes: one clock, synchronous RST
// Notes: bound after the module
`timescale 1ns/1ns
module osc_freq_wdog_chk #(
	parameter int SYSRST_CYCLES = 524288
) (
	input wire logic        REF_CLK,  // clock
	input wire logic        RST,      // reset
	input wire logic [7:0]  ADDR,     // offset
	input wire logic [31:0] WDATA,    // data in
	input wire logic        WR,       // write
	input wire logic        RD,       // read
	input wire logic [31:0] RDATA,    // data out
	input wire logic        ACK,      // accept
	input wire logic        NACK,     // refuse
	input wire logic [6:0]  FREQ_MHZ, // rate
	input wire logic        MS_TICK,  // tick
	input wire logic        SYS_RESET // expiry reset
);
	logic [19:0] hi_q;
	wire logic   f_wr = WR && ADDR == 8'h51;
	wire logic   f_in = WDATA >= 32'h5 && WDATA <= 32'h64;
	wire logic   c_wr = WR && ADDR == 8'hD6;
	wire logic   c_ok = WDATA[31:16] == ~WDATA[15:0];
	// length of the expiry pulse, compared when it ends
	always_ff @(posedge REF_CLK) begin
		if (RST || !SYS_RESET)
			hi_q <= 20'h0;
		else
			hi_q <= hi_q + 20'h1;
	end
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	sequence s_fw; f_wr && f_in; endsequence
	sequence s_fup; ACK ##1 FREQ_MHZ == 7'($past(WDATA, 2)); endsequence
	property p_one; WR |=> ACK != NACK; endproperty
	a_one: assert property (p_one) else $error("write not answered once");
	property p_idle; !WR |=> !ACK && !NACK; endproperty
	a_idle: assert property (p_idle) else $error("answer without write");
	property p_fbad; f_wr && !f_in |=> NACK; endproperty
	a_fbad: assert property (p_fbad) else $error("bad rate accepted");
	property p_fok; s_fw |=> s_fup; endproperty
	a_fok: assert property (p_fok) else $error("rate not taken");
	property p_cbad; c_wr && !c_ok |=> NACK; endproperty
	a_cbad: assert property (p_cbad) else $error("bad timeout accepted");
	property p_cok; c_wr && c_ok |=> ACK; endproperty
	a_cok: assert property (p_cok) else $error("good timeout refused");
	property p_rd0; !RD |=> RDATA == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data without read");
	property p_frd; RD && ADDR == 8'h51 |=> RDATA[31:7] == 25'h0; endproperty
	a_frd: assert property (p_frd) else $error("rate high bits set");
	property p_tick; MS_TICK |=> !MS_TICK [*8]; endproperty
	a_tick: assert property (p_tick) else $error("tick too close");
	property p_rlen; $fell(SYS_RESET) |-> int'(hi_q) == SYSRST_CYCLES; endproperty
	a_rlen: assert property (p_rlen) else $error("reset length wrong");
endmodule
bind osc_freq_wdog osc_freq_wdog_chk #(.SYSRST_CYCLES(SYSRST_CYCLES)) chk_u (
	.REF_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .ACK, .NACK, .FREQ_MHZ, .MS_TICK, .SYS_RESET
);

// *** bench/testbench.sv ***
// Purpose: self-checking bench for osc_freq_wdog
// Assumes: 10 MHz clock, short system reset
// Notes: rate 5 MHz gives a 5000 cycle tick
`timescale 1ns/1ns
module testbench;
	localparam int RL = 16; // short expiry pulse keeps the run brief
	logic        clk = 0, rst = 1, wr = 0, rd = 0, run = 0;
	logic [7:0]  addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        ack, nack, mtick, sres;
	logic [6:0]  fmhz;
	int          num_errors = 0, n_tests = 0, n;
	always #50 clk = ~clk;
	osc_freq_wdog #(.SYSRST_CYCLES(RL)) dut_u (.REF_CLK(clk), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RUN_STATE(run), .RDATA(rdata), .ACK(ack),
		.NACK(nack), .FREQ_MHZ(fmhz), .MS_TICK(mtick), .SYS_RESET(sres));
	task automatic chk(input logic c, input string m);
		n_tests++;
		if (c !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic ok);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1 chk(ack === ok && nack === !ok, "write answer");
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata === e, "read data");
	endtask
	// bounded wait for tick (w=0) or expiry reset (w=1) to reach lv
	task automatic cnt(input int w, input logic lv, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while ((w ? sres : mtick) !== lv && k < 40000);
	endtask
	task automatic t_reset;
		rdc(8'h51, 32'h19);
		rdc(8'hD6, 32'h03E8_03E8);
		rdc(8'hD7, 32'h0D15_AB1E);
		chk(fmhz === 7'h19, "rate out");
	endtask
	task automatic t_freq;
		logic [31:0] v [5] = '{32'h4, 32'h64, 32'h65, 32'h8000_0005, 32'h5};
		logic [6:0]  f [5] = '{7'h19, 7'h64, 7'h64, 7'h64, 7'h05};
		for (int i = 0; i < 5; i++) begin
			wrt(8'h51, v[i], f[i] == v[i][6:0]);
			rdc(8'h51, {25'h0, f[i]});
			chk(fmhz === f[i], "rate out");
		end
		wrt(8'h52, 32'h1, 1'b0);
		rdc(8'h52, 32'h0);
	endtask
	task automatic t_ctrl;
		wrt(8'hD6, 32'h0002_0002, 1'b0);
		rdc(8'hD6, 32'h03E8_03E8);
		wrt(8'hD6, 32'hFFFD_0002, 1'b1);
		rdc(8'hD6, 32'h0002_0002);
	endtask
	task automatic t_tick;
		cnt(0, 1'b1, n);
		cnt(0, 1'b1, n);
		cnt(0, 1'b1, n);
		chk(n == 5000, "tick period");
	endtask
	task automatic t_wdog;
		wrt(8'hD7, 32'h0, 1'b1);
		repeat (12000) @(posedge clk);
		chk(sres === 1'b0, "counted while asleep");
		rdc(8'hD6, 32'h0002_0002);
		wrt(8'hD6, 32'hFFFC_0003, 1'b1);
		rdc(8'hD6, 32'h0003_0003);
		run <= 1'b1;
		cnt(1, 1'b1, n);
		chk(n > 10000 && n <= 15010, "expiry time");
		cnt(1, 1'b0, n);
		chk(n == RL, "reset length");
		rdc(8'hD7, 32'h0D15_AB1E);
		rdc(8'hD6, 32'h03E8_03E8);
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#8_000_000;
		num_errors++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_freq;
		t_ctrl;
		t_tick;
		t_wdog;
		close_out;
	end
endmodule

// *** design/ms_tick_div.sv ***
// Purpose: 1 ms tick generator from the oscillator clock
// Assumes: freq_mhz holds the oscillator rate in whole MHz
// Notes: a new rate takes effect in the next cycle; a count already past the new period ends at once
`timescale 1ns/1ns
module ms_tick_div #(
	parameter int DIV_W = osc_wdog_pkg::DIV_W
) (
	input  wire logic       clk,      // oscillator clock
	input  wire logic       rst,      // synchronous reset, active high
	input  wire logic [6:0] freq_mhz, // programmed rate in MHz
	output logic            tick      // one-cycle pulse each ms
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] period;

	// rate times 1000 cycles per ms
	assign period = DIV_W'({10'h000, freq_mhz}) * DIV_W'(osc_wdog_pkg::CYCLES_PER_MS_MHZ);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q >= period - DIV_W'(1)) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + DIV_W'(1);
			tick  <= 1'b0;
		end
	end
endmodule

// *** design/osc_freq_wdog.sv ***
// Purpose: oscillator frequency setting and 1 kHz count-down watchdog
// Assumes: REF_CLK is the oscillator clock; RUN_STATE is asynchronous
// Notes: writes answered by ACK or NACK one cycle after the strobe
`timescale 1ns/1ns
module osc_freq_wdog #(
	parameter int SYSRST_CYCLES = osc_wdog_pkg::SYSRST_CYCLES
) (
	input  wire logic        REF_CLK,   // oscillator clock
	input  wire logic        RST,       // synchronous reset, active high
	input  wire logic [7:0]  ADDR,      // register offset
	input  wire logic [31:0] WDATA,     // write data
	input  wire logic        WR,        // write strobe
	input  wire logic        RD,        // read strobe
	input  wire logic        RUN_STATE, // running power state level
	output logic      [31:0] RDATA,     // read data, cycle after RD
	output logic             ACK,       // write accepted pulse
	output logic             NACK,      // write refused pulse
	output logic      [6:0]  FREQ_MHZ,  // frequency to timebase users
	output logic             MS_TICK,   // 1 ms timebase pulse
	output logic             SYS_RESET  // watchdog system reset
);
	logic [6:0]                       freq_q;
	logic [15:0]                      timeout_q;
	logic [15:0]                      count_q;
	logic [31:0]                      dis_key_q;
	logic                             enabled_q;
	logic                             run_meta_q;
	logic                             run_q;
	logic [osc_wdog_pkg::SYSRST_W-1:0] rst_cnt_q;
	logic                             tick;
	logic                             wr_freq;
	logic                             wr_ctrl;
	logic                             wr_dis;
	logic                             freq_ok;
	logic                             ctrl_ok;
	logic                             expire;
	logic                             wd_clear;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr_freq = WR && hit(ADDR, osc_wdog_pkg::OFF_OSC_FREQ);
	assign wr_ctrl = WR && hit(ADDR, osc_wdog_pkg::OFF_WDOG_CTRL);
	assign wr_dis  = WR && hit(ADDR, osc_wdog_pkg::OFF_WDOG_DISABLE);

	// whole word checked, so stray high bits also refuse the write
	assign freq_ok = (WDATA >= osc_wdog_pkg::FREQ_MIN) &&
		(WDATA <= osc_wdog_pkg::FREQ_MAX);
	assign ctrl_ok = (WDATA[osc_wdog_pkg::WD_CPL_LSB +: osc_wdog_pkg::WD_W] ==
		~WDATA[osc_wdog_pkg::WD_TIMEOUT_LSB +: osc_wdog_pkg::WD_W]);

	// a system reset in progress also returns the watchdog to defaults
	assign wd_clear = RST || SYS_RESET;

	// power state comes from another domain
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			run_meta_q <= 1'b0;
			run_q      <= 1'b0;
		end else begin
			run_meta_q <= RUN_STATE;
			run_q      <= run_meta_q;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			freq_q <= osc_wdog_pkg::FREQ_RESET;
		end else if (wr_freq && freq_ok) begin
			freq_q <= WDATA[osc_wdog_pkg::FREQ_LSB +: osc_wdog_pkg::FREQ_W];
		end
	end

	ms_tick_div #(
		.DIV_W(osc_wdog_pkg::DIV_W)
	) u_tick (
		.clk     (REF_CLK),
		.rst     (RST),
		.freq_mhz(freq_q),
		.tick    (tick)
	);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			FREQ_MHZ <= osc_wdog_pkg::FREQ_RESET;
			MS_TICK  <= 1'b0;
		end else begin
			FREQ_MHZ <= freq_q;
			MS_TICK  <= tick;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (wd_clear) begin
			dis_key_q <= osc_wdog_pkg::WD_DISABLE_MAGIC;
			enabled_q <= 1'b0;
		end else if (wr_dis) begin
			dis_key_q <= WDATA;
			if (WDATA == osc_wdog_pkg::WD_ENABLE_VALUE) begin
				enabled_q <= 1'b1;
			end else if (WDATA == osc_wdog_pkg::WD_DISABLE_MAGIC) begin
				enabled_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (wd_clear) begin
			timeout_q <= osc_wdog_pkg::WD_TIMEOUT_RESET;
		end else if (wr_ctrl && ctrl_ok) begin
			timeout_q <= WDATA[osc_wdog_pkg::WD_TIMEOUT_LSB +: osc_wdog_pkg::WD_W];
		end
	end

	// expiry on the tick seen with the count at one or at zero
	assign expire = enabled_q && run_q && tick && (count_q <= 16'h0001);

	always_ff @(posedge REF_CLK) begin
		if (wd_clear) begin
			count_q <= osc_wdog_pkg::WD_TIMEOUT_RESET;
		end else if (wr_ctrl && ctrl_ok) begin
			count_q <= WDATA[osc_wdog_pkg::WD_TIMEOUT_LSB +: osc_wdog_pkg::WD_W];
		end else if (wr_dis && WDATA == osc_wdog_pkg::WD_DISABLE_MAGIC) begin
			count_q <= timeout_q;
		end else if (expire) begin
			count_q <= 16'h0000;
		end else if (enabled_q && run_q && tick) begin
			count_q <= count_q - 16'h0001;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rst_cnt_q <= '0;
			SYS_RESET <= 1'b0;
		end else if (expire) begin
			rst_cnt_q <= osc_wdog_pkg::SYSRST_W'(SYSRST_CYCLES - 1);
			SYS_RESET <= 1'b1;
		end else if (rst_cnt_q != '0) begin
			rst_cnt_q <= rst_cnt_q - osc_wdog_pkg::SYSRST_W'(1);
		end else begin
			SYS_RESET <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ACK  <= 1'b0;
			NACK <= 1'b0;
		end else if (WR) begin
			unique case (1'b1)
				wr_freq: begin
					ACK  <= freq_ok;
					NACK <= !freq_ok;
				end
				wr_ctrl: begin
					ACK  <= ctrl_ok;
					NACK <= !ctrl_ok;
				end
				wr_dis: begin
					ACK  <= 1'b1;
					NACK <= 1'b0;
				end
				default: begin
					ACK  <= 1'b0;
					NACK <= 1'b1;
				end
			endcase
		end else begin
			ACK  <= 1'b0;
			NACK <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else if (RD && hit(ADDR, osc_wdog_pkg::OFF_OSC_FREQ)) begin
			RDATA <= {25'h000_0000, freq_q};
		end else if (RD && hit(ADDR, osc_wdog_pkg::OFF_WDOG_CTRL)) begin
			RDATA <= {count_q, timeout_q};
		end else if (RD && hit(ADDR, osc_wdog_pkg::OFF_WDOG_DISABLE)) begin
			RDATA <= dis_key_q;
		end else begin
			RDATA <= 32'h0000_0000;
		end
	end
endmodule

// *** design/osc_wdog_pkg.sv ***
// Purpose: shared constants of the oscillator frequency and watchdog block
// Assumes: registers addressed by their 8-bit printed offsets
// Notes: none
package osc_wdog_pkg;
	// register offsets
	localparam logic [7:0]  OFF_OSC_FREQ      = 8'h51;
	localparam logic [7:0]  OFF_WDOG_CTRL     = 8'hD6;
	localparam logic [7:0]  OFF_WDOG_DISABLE  = 8'hD7;

	// frequency field
	localparam int          FREQ_W            = 7;
	localparam int          FREQ_LSB          = 0;
	localparam logic [6:0]  FREQ_RESET        = 7'h19;
	localparam logic [31:0] FREQ_MIN          = 32'h0000_0005;
	localparam logic [31:0] FREQ_MAX          = 32'h0000_0064;

	// watchdog control fields
	localparam int          WD_W              = 16;
	localparam int          WD_TIMEOUT_LSB    = 0;
	localparam int          WD_COUNT_LSB      = 16;
	localparam int          WD_CPL_LSB        = 16;
	localparam logic [15:0] WD_TIMEOUT_RESET  = 16'h03E8;

	// disable register
	localparam logic [31:0] WD_DISABLE_MAGIC  = 32'h0D15_AB1E;
	localparam logic [31:0] WD_ENABLE_VALUE   = 32'h0000_0000;

	// timing: one tick is 1 ms, i.e. 1000 cycles per MHz
	localparam int          TICK_US           = 1000;
	localparam int          DIV_W             = 17;
	localparam logic [16:0] CYCLES_PER_MS_MHZ = 17'(TICK_US);

	// system reset length in oscillator cycles
	localparam int          SYSRST_CYCLES     = 524288;
	localparam int          SYSRST_W          = 20;
endpackage
